// >>> design/ads_pkg.sv
// Constants shared by the target address and soft reset register pair.
`default_nettype none

package ads_pkg;

  // ----------------------------------------------------------------------
  // Register offsets on the serial control bus
  // ----------------------------------------------------------------------
  localparam logic [7:0] ADS_ADDR_CFG_OFS = 8'h00;
  localparam logic [7:0] ADS_RST_CTL_OFS = 8'h01;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int ADS_ADDR_MSB = 7;
  localparam int ADS_ADDR_LSB = 1;
  localparam int ADS_SRC_SEL_BIT = 0;
  localparam int ADS_VRX_RST_BIT = 4;
  localparam int ADS_FULL_RST_BIT = 1;
  localparam int ADS_LOGIC_RST_BIT = 0;

  // ----------------------------------------------------------------------
  // Values after reset and cycle counts
  // ----------------------------------------------------------------------
  localparam logic [6:0] ADS_ADDR_RST = 7'h00;
  localparam logic ADS_SRC_SEL_RST = 1'b0;
  localparam logic [7:0] ADS_RDATA_RST = 8'h00;
  // Cycle after reset release in which the synchronised strap is caught.
  localparam logic [1:0] ADS_CAP_AT = 2'h2;

endpackage

`default_nettype wire

// >>> design/ads_regs.sv
// Target address and self-clearing soft reset registers.
`default_nettype none

module ads_regs (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Strap level, already decoded to an address, from the pin
  input wire logic [6:0] address_strap_pin,
  // Register access from the serial control bus engine
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Address the bus engine must answer at
  output logic [6:0] active_target_address,
  // Reset pulses to the rest of the device
  output logic video_rx_reset,
  output logic full_digital_reset,
  output logic logic_only_reset,
  output logic default_restore
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [6:0] strap_s1;
    logic [6:0] strap_s2;
    logic [6:0] strap_r;
    logic [1:0] cap_cnt;
    logic [6:0] dev_addr;
    logic src_sel;
    logic vrx_rst;
    logic full_rst;
    logic logic_rst;
    logic restore;
    logic [6:0] active;
    logic [7:0] rdata;
  } ads_state_t;

  ads_state_t st_r;
  ads_state_t st_nxt;

  // Write to one register of this pair.
  function automatic logic hit(input logic en, input logic [7:0] a,
                               input logic [7:0] ofs);
    hit = en && (a == ofs);
  endfunction

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  // A full reset restarts everything, including the strap capture, so the
  // address is briefly zero until the strap is caught again.
  always_comb begin
    st_nxt = st_r;
    st_nxt.strap_s1 = address_strap_pin;
    st_nxt.strap_s2 = st_r.strap_s1;
    // Reset bits live one cycle only.
    st_nxt.vrx_rst = 1'b0;
    st_nxt.full_rst = 1'b0;
    st_nxt.logic_rst = 1'b0;
    st_nxt.restore = 1'b0;
    // The counter stops at its top so the strap is caught once per reset;
    // a free count would keep reloading it over a programmed address.
    if (st_r.cap_cnt != 2'h3) begin
      st_nxt.cap_cnt = st_r.cap_cnt + 2'h1;
    end
    if (st_r.cap_cnt == ads_pkg::ADS_CAP_AT) begin
      // Two cycles of synchroniser have settled by now.
      st_nxt.strap_r = st_r.strap_s2;
      st_nxt.dev_addr = st_r.strap_s2;
    end
    if (hit(reg_wr_en, reg_addr, ads_pkg::ADS_ADDR_CFG_OFS)) begin
      st_nxt.dev_addr = reg_wdata[ads_pkg::ADS_ADDR_MSB:ads_pkg::ADS_ADDR_LSB];
      st_nxt.src_sel = reg_wdata[ads_pkg::ADS_SRC_SEL_BIT];
    end
    if (hit(reg_wr_en, reg_addr, ads_pkg::ADS_RST_CTL_OFS)) begin
      st_nxt.vrx_rst = reg_wdata[ads_pkg::ADS_VRX_RST_BIT];
      st_nxt.full_rst = reg_wdata[ads_pkg::ADS_FULL_RST_BIT];
      st_nxt.logic_rst = reg_wdata[ads_pkg::ADS_LOGIC_RST_BIT];
    end
    // Placed after the writes, so a logic-only reset wins a clash with a
    // write to the address register in the same cycle.
    if (st_r.logic_rst) begin
      // Registers survive, but strapped and listed ones go to default.
      st_nxt.dev_addr = st_r.strap_r;
      st_nxt.src_sel = ads_pkg::ADS_SRC_SEL_RST;
      st_nxt.restore = 1'b1;
    end
    if (reg_rd_en) begin
      unique case (reg_addr)
        ads_pkg::ADS_ADDR_CFG_OFS: st_nxt.rdata = {st_r.dev_addr,
                                                   st_r.src_sel};
        ads_pkg::ADS_RST_CTL_OFS: st_nxt.rdata = {3'h0, st_r.vrx_rst, 2'h0,
                                                  st_r.full_rst,
                                                  st_r.logic_rst};
        default: st_nxt.rdata = ads_pkg::ADS_RDATA_RST;
      endcase
    end
    // Chosen address follows the source select.
    st_nxt.active = st_r.src_sel ? st_r.dev_addr : st_r.strap_r;
    if (st_r.full_rst) begin
      // Everything but the strap synchroniser returns to reset state.
      st_nxt = '0;
      st_nxt.strap_s1 = address_strap_pin;
      st_nxt.strap_s2 = st_r.strap_s1;
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // All come straight from the state register.
  assign reg_rdata = st_r.rdata;
  assign active_target_address = st_r.active;
  assign video_rx_reset = st_r.vrx_rst;
  assign full_digital_reset = st_r.full_rst;
  assign logic_only_reset = st_r.logic_rst;
  assign default_restore = st_r.restore;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Write strobe aimed at the reset register, shared by the pulse checks.
  logic wr_rst_reg;
  assign wr_rst_reg = hit(reg_wr_en, reg_addr, ads_pkg::ADS_RST_CTL_OFS);

  // The strap lands in the address field once the synchroniser settles.
  strap_load_a: assert property (
    (st_r.cap_cnt == ads_pkg::ADS_CAP_AT) && !st_r.full_rst && !reg_wr_en
    |=> (st_r.dev_addr == $past(st_r.strap_s2))
        && (st_r.strap_r == $past(st_r.strap_s2)))
    else $error("strap not captured into address field");

  // The answered address follows the source select one edge later.
  addr_select_a: assert property (
    !st_r.full_rst |=> active_target_address ==
      ($past(st_r.src_sel) ? $past(st_r.dev_addr) : $past(st_r.strap_r)))
    else $error("active address does not follow source select");

  // Each reset bit stands for exactly one cycle after its write.
  vrx_pulse_a: assert property (
    wr_rst_reg && reg_wdata[4] && !st_r.full_rst
    |=> video_rx_reset ##1 !video_rx_reset)
    else $error("video receiver reset not a single pulse");

  // A full reset clears the registers and restarts the strap capture.
  full_pulse_a: assert property (
    wr_rst_reg && reg_wdata[1] && !st_r.full_rst
    |=> full_digital_reset ##1 (!full_digital_reset && !st_r.src_sel
        && st_r.dev_addr == 7'h00 && st_r.cap_cnt == 2'h0))
    else $error("full reset did not clear registers");

  // The logic-only reset bit clears itself after one cycle.
  logic_pulse_a: assert property (
    wr_rst_reg && reg_wdata[0] && !st_r.full_rst
    |=> logic_only_reset ##1 !logic_only_reset)
    else $error("logic-only reset not a single pulse");

  // The strapped copy, not the bus, supplies the reloaded address.
  strap_reload_a: assert property (
    logic_only_reset && !full_digital_reset && !reg_wr_en
    |=> st_r.dev_addr == $past(st_r.strap_r))
    else $error("strap value not reloaded");

  // Other banks are told to reload their defaults right after.
  restore_pulse_a: assert property (
    logic_only_reset && !full_digital_reset
    |=> default_restore && !st_r.src_sel)
    else $error("logic-only reset did not restore defaults");

  // A plain write to the address register lands whole on the next edge.
  addr_write_a: assert property (
    hit(reg_wr_en, reg_addr, ads_pkg::ADS_ADDR_CFG_OFS) && !st_r.full_rst
    && !st_r.logic_rst
    |=> {st_r.dev_addr, st_r.src_sel} == $past(reg_wdata))
    else $error("address register write did not land");

  // Read data must stand until the next read, as the bus engine may
  // shift it out over many of its own bit times.
  rdata_hold_a: assert property (
    !reg_rd_en && !st_r.full_rst |=> $stable(reg_rdata))
    else $error("read data changed without a read");

  // Reserved bits of the reset register always read as zero.
  rst_reserved_a: assert property (
    reg_rd_en && reg_addr == ads_pkg::ADS_RST_CTL_OFS && !st_r.full_rst
    |=> reg_rdata[7:5] == 3'h0 && reg_rdata[3:2] == 2'h0)
    else $error("reserved reset bits read as one");

  // Main scenarios: programmed address, both soft resets, receiver reset.

  cover_addr_prog_c: cover property (
    hit(reg_wr_en, reg_addr, ads_pkg::ADS_ADDR_CFG_OFS) && reg_wdata[0]
    ##2 st_r.active != 7'h00);
  cover_logic_rst_c: cover property (logic_only_reset ##1 default_restore);
  cover_full_rst_c: cover property (full_digital_reset ##4
    st_r.cap_cnt == 2'h3);
  cover_vrx_rst_c: cover property (video_rx_reset ##1 !video_rx_reset);

endmodule

`default_nettype wire

// >>> sim/ads_host.sv
// Host model that issues register strobes as the bus engine would.
`default_nettype none
module ads_host (
  // Clock
  input wire logic clk,
  // Register strobe bus
  output logic wr_en,
  output logic rd_en,
  output logic [7:0] addr,
  output logic [7:0] wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  // Bus idles with strobes low from time zero.
  initial begin
    {wr_en, rd_en, addr, wdata} = 18'h0;
  end
  // Only 3.3 V signalling exists here, so soft resets are legal
  // The bridge control restore bit lies outside this bank
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    {wr_en, addr, wdata} = {1'b1, a, d};
    @(negedge clk);
    // Inverted leftovers so that a stale bus is never mistaken for data.
    {wr_en, addr, wdata} = {1'b0, ~a, ~d};
  endtask
  task automatic read(input logic [7:0] a);
    @(negedge clk);
    {rd_en, addr} = {1'b1, a};
    @(negedge clk);
    {rd_en, addr} = {1'b0, ~a};
    @(negedge clk);
  endtask
endmodule
`default_nettype wire

// >>> sim/ads_regs_bench.sv
// Self-checking bench for the address and soft reset register pair.
`default_nettype none
module ads_regs_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [6:0] strap = 7'h2c;
  logic wr_en, rd_en, vrx, full, lrst, rest;
  logic [7:0] addr, wdata, rdata;
  logic [6:0] act;
  int err_count = 0;
  int cmp_count = 0;
  // Free running 10 MHz clock.
  always #50 clk = ~clk;
  ads_host u_ads_host (.clk(clk), .wr_en(wr_en), .rd_en(rd_en),
    .addr(addr), .wdata(wdata));
  ads_regs u_ads_regs (.clk(clk), .rst(rst), .address_strap_pin(strap),
    .reg_wr_en(wr_en), .reg_rd_en(rd_en), .reg_addr(addr),
    .reg_wdata(wdata), .reg_rdata(rdata), .active_target_address(act),
    .video_rx_reset(vrx), .full_digital_reset(full),
    .logic_only_reset(lrst), .default_restore(rest));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    u_ads_host.read(a);
    chk(rdata, exp);
  endtask
  // Pulses must last exactly one cycle; restore trails the logic reset.
  // The write returns at the falling edge after the strobe, which is the
  // one cycle in which the pulses stand.
  task automatic pulse(input logic [7:0] d);
    u_ads_host.write(8'h01, d);
    chk({5'h0, vrx, full, lrst}, {5'h0, d[4], d[1], d[0]});
    @(negedge clk);
    chk({6'h0, rest, vrx | full | lrst}, {6'h0, d[0], 1'b0});
  endtask
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Main sequence; strap 0x2c reads back as 0x58 with the select bit low.
  initial begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    repeat (6) @(negedge clk);
    rd(8'h00, 8'h58);
    chk({1'b0, act}, 8'h2c);
    u_ads_host.write(8'h00, 8'ha3);
    rd(8'h00, 8'ha3);
    chk({1'b0, act}, 8'h51);
    rd(8'h05, 8'h00);
    $display("test address done");
    pulse(8'h10);
    rd(8'h01, 8'h00);
    pulse(8'h01);
    rd(8'h00, 8'h58);
    chk({1'b0, act}, 8'h2c);
    $display("test logic reset done");
    u_ads_host.write(8'h00, 8'ha3);
    pulse(8'h02);
    // Host duty after a full reset; that offset lies outside this bank
    // and must leave the address register alone.
    u_ads_host.write(8'h4f, 8'h02);
    repeat (8) @(negedge clk);
    rd(8'h00, 8'h58);
    chk({1'b0, act}, 8'h2c);
    rd(8'h01, 8'h00);
    $display("test full reset done");
    wrap_up();
  end
  // Watchdog: the tests need about 60 cycles.
  initial begin
    repeat (400) @(posedge clk);
    err_count++;
    wrap_up();
  end
endmodule
`default_nettype wire
